// [transfer_arith_regs.svh]
/*
  Constants for the transfer and arithmetic execute block: flag bit
  positions, reset values, address forming and decimal adjust figures.
  Assumes inclusion by bare name from the design files.
*/
`ifndef TRANSFER_ARITH_REGS_SVH
`define TRANSFER_ARITH_REGS_SVH

// Flag positions inside the flag register
`define FLAG_C_BIT      0
`define FLAG_V_BIT      1
`define FLAG_Z_BIT      2
`define FLAG_N_BIT      3
`define FLAG_H_BIT      5
`define FLAGS_RESET     8'h00

// Register file
`define GEN_REG_COUNT   8
`define STACK_PTR_IDX   3'h7
`define GEN_REG_RESET   16'h0000

// Address forming
`define ABS8_PAGE       8'hFF
`define WORD_EVEN_MASK  16'hFFFE
`define STEP_BYTE       16'h0001
`define STEP_WORD       16'h0002

// Decimal adjust
`define BCD_LOW_FIX     8'h06
`define BCD_HIGH_FIX    8'h60
`define BCD_DIGIT_MAX   4'h9
`define BCD_BYTE_MAX    8'h99

`endif

// [transfer_arith_pkg.sv]
/*
  Types shared by the execute block, the memory model and the bench: operation and
  addressing mode codes, the command carrier, flags and memory request.
  Assumes the constants header sits in the same folder.
*/
package transfer_arith_pkg;

  typedef enum logic [3:0] {
    transfer_op,
    stack_store_op,
    stack_load_op,
    sum_op,
    difference_op,
    sum_with_carry_op,
    difference_with_borrow_op,
    plus_one_op,
    minus_one_op,
    pointer_plus_small_op,
    pointer_minus_small_op,
    bcd_fix_after_sum_op,
    bcd_fix_after_difference_op,
    peripheral_out_transfer_op,
    peripheral_in_transfer_op,
    other_op
  } op_t;

  typedef enum logic [2:0] {
    mode_register,
    mode_indirect,
    mode_disp16,
    mode_post_inc,
    mode_pre_decrement,
    mode_abs8,
    mode_abs16,
    mode_immediate
  } mode_t;

  // Byte register index: [2:0] general_reg number, [3] set selects low byte
  typedef struct packed {
    op_t         op;
    logic        word;
    mode_t       mode;
    logic        store;
    logic [3:0]  reg_a;
    logic [3:0]  reg_b;
    logic [15:0] ext;
  } cmd_t;

  typedef struct packed {
    logic [1:0] upper;
    logic       h;
    logic       spare;
    logic       n;
    logic       z;
    logic       v;
    logic       c;
  } flags_t;

  typedef struct packed {
    logic        req;
    logic        we;
    logic        word;
    logic [15:0] addr;
    logic [15:0] wdata;
  } mem_out_t;

  typedef enum logic [1:0] {st_idle, st_fetch, st_exec, st_mem} fsm_t;

  typedef struct packed {
    fsm_t     fsm;
    cmd_t     cmd;
    logic     ready;
    logic     done;
    logic     illegal;
    mem_out_t mem;
    flags_t   flags;
  } core_state_t;

endpackage : transfer_arith_pkg

// [gen_reg_file.sv]
/*
  General register file: entries of sixteen bits with two byte lanes,
  two registered read ports and one write port with byte enables.
  Assumes reads are issued one cycle before the data are used.
*/
`timescale 1ns/1ps
`include "transfer_arith_regs.svh"

module gen_reg_file #(
  parameter int NREG = `GEN_REG_COUNT,
  parameter int AW   = 3
) (
  // Clock and reset
  input  wire logic          clk,
  input  wire logic          resetn,
  // Read ports
  input  wire logic [AW-1:0] ra_idx,
  input  wire logic [AW-1:0] rb_idx,
  output logic      [15:0]   ra_data,
  output logic      [15:0]   rb_data,
  // Write port
  input  wire logic          we,
  input  wire logic [AW-1:0] widx,
  input  wire logic [1:0]    wbe,
  input  wire logic [15:0]   wdata
);

  logic [NREG-1:0][15:0] file_reg;
  logic [NREG-1:0][15:0] file_next;
  logic [15:0]           rda_reg;
  logic [15:0]           rdb_reg;

  ////////////////////////////////////////////////////////////////////////
  // Byte-lane write per entry
  for (genvar g = 0; g < NREG; g++) begin : g_entry
    assign file_next[g][15:8] = (we && widx == AW'(g) && wbe[1]) ? wdata[15:8] : file_reg[g][15:8];
    assign file_next[g][7:0]  = (we && widx == AW'(g) && wbe[0]) ? wdata[7:0]  : file_reg[g][7:0];
  end

  ////////////////////////////////////////////////////////////////////////
  // Old data on a same-cycle write; callers never rely on bypass
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      file_reg <= '0;
      rda_reg  <= `GEN_REG_RESET;
      rdb_reg  <= `GEN_REG_RESET;
    end else begin
      file_reg <= file_next;
      rda_reg  <= file_reg[ra_idx];
      rdb_reg  <= file_reg[rb_idx];
    end
  end

  assign ra_data = rda_reg;
  assign rb_data = rdb_reg;

endmodule : gen_reg_file

// [transfer_arith_exec.sv]
/*
  Execute block for the transfer and arithmetic groups: takes one decoded
  command at a time, reads general registers, computes, touches memory
  and updates the flag register.
  Assumes a memory that holds mem_ack for one cycle per request and an
  upstream decoder that follows the command layout in the package.
*/
`timescale 1ns/1ps
`include "transfer_arith_regs.svh"

// Notes on behaviour
// - Transfer register, memory or immediate, byte/word
// - Listed transfer modes other than short absolute take byte and word
// - Short absolute mode is byte only
// - Peripheral-synchronised transfers are not implemented
// - Stack store: pre-decrement pointer, word write
// - Stack load: word read from the old pointer, pointer incremented when the read is issued
// - Add/subtract registers; add also takes immediate
// - No immediate form of plain subtract
// - Word add/subtract only between registers
// - Carry add, borrow subtract on bytes only
// - Increment/decrement byte register by exactly one
// - Pointer adjust word register by 1 or 2
// - Decimal adjust byte from flags into BCD
// - Word access forces address bit zero low
// - Pointer step 1 for byte, 2 for word
// - Short absolute address has upper byte ones
module transfer_arith_exec (
  // Clock and reset
  input  wire logic                         clk,
  input  wire logic                         resetn,
  // Command from the decoder
  input  wire logic                         cmd_valid,
  input  wire transfer_arith_pkg::cmd_t     cmd,
  output logic                              cmd_ready,
  output logic                              done,
  output logic                              illegal,
  // Memory over the internal bus
  output transfer_arith_pkg::mem_out_t      mem,
  input  wire logic [15:0]                  mem_rdata,
  input  wire logic                         mem_ack,
  // Condition codes
  output transfer_arith_pkg::flags_t        flags
);
  import transfer_arith_pkg::*;

  core_state_t st_reg;
  core_state_t st_next;

  logic [15:0] rf_a;
  logic [15:0] rf_b;
  logic [2:0]  rf_b_idx;
  logic        rf_we;
  logic [2:0]  rf_widx;
  logic [1:0]  rf_be;
  logic [15:0] rf_wdata;

  cmd_t        c;
  logic        in_exec;
  logic        is_stack;
  logic        x_word;
  logic        x_store;
  mode_t       x_mode;
  logic [2:0]  ptr_idx;
  logic [15:0] step;
  logic [15:0] ea;
  logic [7:0]  a_byte;
  logic [7:0]  b_byte;
  logic        refuse;
  logic [15:0] opnd_a;
  logic [15:0] opnd_b;
  logic        sub;
  logic        cin;
  logic [16:0] res17;
  logic [12:0] half13;
  logic [4:0]  half5;
  logic [15:0] arith_res;
  logic        res_sign;
  logic        a_sign;
  logic        b_sign;
  logic [7:0]  bcd_fix;
  logic [7:0]  bcd_res;
  logic        bcd_c;

  function automatic logic [7:0] pick_byte(input logic [15:0] w, input logic low);
    pick_byte = low ? w[7:0] : w[15:8];
  endfunction : pick_byte

  ////////////////////////////////////////////////////////////////////////
  // Register file
  gen_reg_file #(
    .NREG (`GEN_REG_COUNT),
    .AW   (3)
  ) u_regs (
    .clk     (clk),
    .resetn  (resetn),
    .ra_idx  (st_reg.cmd.reg_a[2:0]),
    .rb_idx  (rf_b_idx),
    .ra_data (rf_a),
    .rb_data (rf_b),
    .we      (rf_we),
    .widx    (rf_widx),
    .wbe     (rf_be),
    .wdata   (rf_wdata)
  );

  ////////////////////////////////////////////////////////////////////////
  // Operand and address forming
  always_comb begin
    c        = st_reg.cmd;
    in_exec  = (st_reg.fsm == st_exec);
    is_stack = (c.op == stack_store_op) || (c.op == stack_load_op);
    // Stack forms are word transfers through the stack pointer
    x_word   = is_stack ? 1'b1 : c.word;
    x_store  = is_stack ? (c.op == stack_store_op) : c.store;
    x_mode   = (c.op == stack_store_op) ? mode_pre_decrement :
               (c.op == stack_load_op)  ? mode_post_inc : c.mode;
    ptr_idx  = is_stack ? `STACK_PTR_IDX : c.reg_b[2:0];
    rf_b_idx = ptr_idx;
    step     = x_word ? `STEP_WORD : `STEP_BYTE;
    a_byte   = pick_byte(rf_a, c.reg_a[3]);
    b_byte   = pick_byte(rf_b, c.reg_b[3]);
    case (x_mode)
      mode_disp16:        ea = rf_b + c.ext;
      mode_pre_decrement: ea = rf_b - step;
      mode_abs8:          ea = {`ABS8_PAGE, c.ext[7:0]};
      mode_abs16:         ea = c.ext;
      default:            ea = rf_b;
    endcase
    if (x_word) begin
      ea = ea & `WORD_EVEN_MASK;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Forms that are refused before any effect
  always_comb begin
    case (c.op)
      transfer_op:
        refuse = (x_mode == mode_abs8 && x_word) ||
                 (x_mode == mode_immediate && x_store);
      stack_store_op, stack_load_op:
        refuse = 1'b0;
      sum_op:
        refuse = (c.mode != mode_register && c.mode != mode_immediate) ||
                 (c.word && c.mode == mode_immediate);
      difference_op:
        refuse = (c.mode != mode_register);
      sum_with_carry_op, difference_with_borrow_op:
        refuse = c.word || (c.mode != mode_register && c.mode != mode_immediate);
      plus_one_op, minus_one_op:
        refuse = c.word;
      pointer_plus_small_op, pointer_minus_small_op:
        refuse = (c.ext != `STEP_BYTE) && (c.ext != `STEP_WORD);
      bcd_fix_after_sum_op, bcd_fix_after_difference_op:
        refuse = c.word;
      default:
        refuse = 1'b1;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // Adder shared by all arithmetic forms but decimal adjust
  always_comb begin
    sub    = (c.op == difference_op) || (c.op == difference_with_borrow_op) ||
             (c.op == minus_one_op) || (c.op == pointer_minus_small_op);
    cin    = ((c.op == sum_with_carry_op) || (c.op == difference_with_borrow_op)) ? st_reg.flags.c : 1'b0;
    opnd_a = c.word ? rf_a : {8'h00, a_byte};
    case (c.op)
      plus_one_op, minus_one_op:                     opnd_b = 16'h0001;
      pointer_plus_small_op, pointer_minus_small_op: opnd_b = c.ext;
      default: opnd_b = (c.mode == mode_immediate) ? {8'h00, c.ext[7:0]} :
                        (c.word ? rf_b : {8'h00, b_byte});
    endcase
    if (c.op == pointer_plus_small_op || c.op == pointer_minus_small_op) begin
      opnd_a = rf_a;
    end
    res17  = sub ? ({1'b0, opnd_a} - {1'b0, opnd_b} - {16'h0000, cin}) :
                   ({1'b0, opnd_a} + {1'b0, opnd_b} + {16'h0000, cin});
    half13 = sub ? ({1'b0, opnd_a[11:0]} - {1'b0, opnd_b[11:0]} - {12'h000, cin}) :
                   ({1'b0, opnd_a[11:0]} + {1'b0, opnd_b[11:0]} + {12'h000, cin});
    half5  = sub ? ({1'b0, opnd_a[3:0]} - {1'b0, opnd_b[3:0]} - {4'h0, cin}) :
                   ({1'b0, opnd_a[3:0]} + {1'b0, opnd_b[3:0]} + {4'h0, cin});
    arith_res = c.word ? res17[15:0] : {8'h00, res17[7:0]};
    res_sign  = c.word ? res17[15] : res17[7];
    a_sign    = c.word ? opnd_a[15] : opnd_a[7];
    b_sign    = c.word ? opnd_b[15] : opnd_b[7];
  end

  ////////////////////////////////////////////////////////////////////////
  // Decimal adjust from the carry and half-carry left by the last sum or difference
  always_comb begin
    bcd_fix = 8'h00;
    bcd_c   = st_reg.flags.c;
    if (c.op == bcd_fix_after_sum_op) begin
      if (st_reg.flags.h || a_byte[3:0] > `BCD_DIGIT_MAX) begin
        bcd_fix = bcd_fix | `BCD_LOW_FIX;
      end
      if (st_reg.flags.c || a_byte > `BCD_BYTE_MAX) begin
        bcd_fix = bcd_fix | `BCD_HIGH_FIX;
        bcd_c   = 1'b1;
      end
      bcd_res = a_byte + bcd_fix;
    end else begin
      if (st_reg.flags.h) begin
        bcd_fix = bcd_fix | `BCD_LOW_FIX;
      end
      if (st_reg.flags.c) begin
        bcd_fix = bcd_fix | `BCD_HIGH_FIX;
      end
      bcd_res = a_byte - bcd_fix;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Sequencer
  always_comb begin
    st_next         = st_reg;
    st_next.done    = 1'b0;
    st_next.illegal = 1'b0;
    rf_we           = 1'b0;
    rf_widx         = c.reg_a[2:0];
    rf_be           = c.reg_a[3] ? 2'b01 : 2'b10;
    rf_wdata        = 16'h0000;
    case (st_reg.fsm)
      st_idle: begin
        st_next.ready = 1'b1;
        if (cmd_valid && st_reg.ready) begin
          st_next.cmd   = cmd;
          st_next.ready = 1'b0;
          st_next.fsm   = st_fetch;
        end
      end
      st_fetch: begin
        st_next.fsm = st_exec;
      end
      st_exec: begin
        st_next.fsm   = st_idle;
        st_next.ready = 1'b1;
        st_next.done  = 1'b1;
        if (refuse) begin
          st_next.illegal = 1'b1;
        end else if (c.op == transfer_op || is_stack) begin
          if (x_mode == mode_register || x_mode == mode_immediate) begin
            rf_we    = 1'b1;
            rf_wdata = (x_mode == mode_immediate) ? (x_word ? c.ext : {2{c.ext[7:0]}}) :
                       (x_word ? rf_b : {2{b_byte}});
            rf_be    = x_word ? 2'b11 : rf_be;
            st_next.flags.n = x_word ? rf_wdata[15] : rf_wdata[7];
            st_next.flags.z = x_word ? (rf_wdata == 16'h0000) : (rf_wdata[7:0] == 8'h00);
            st_next.flags.v = 1'b0;
          end else begin
            if (x_mode == mode_pre_decrement || x_mode == mode_post_inc) begin
              rf_we    = 1'b1;
              rf_widx  = ptr_idx;
              rf_be    = 2'b11;
              rf_wdata = (x_mode == mode_pre_decrement) ? rf_b - step : rf_b + step;
            end
            st_next.mem.req   = 1'b1;
            st_next.mem.we    = x_store;
            st_next.mem.word  = x_word;
            st_next.mem.addr  = ea;
            st_next.mem.wdata = x_word ? rf_a : {8'h00, a_byte};
            if (x_store) begin
              st_next.flags.n = x_word ? rf_a[15] : a_byte[7];
              st_next.flags.z = x_word ? (rf_a == 16'h0000) : (a_byte == 8'h00);
              st_next.flags.v = 1'b0;
            end
            st_next.fsm   = st_mem;
            st_next.ready = 1'b0;
            st_next.done  = 1'b0;
          end
        end else if (c.op == pointer_plus_small_op || c.op == pointer_minus_small_op) begin
          rf_we    = 1'b1;
          rf_be    = 2'b11;
          rf_wdata = res17[15:0];
        end else if (c.op == bcd_fix_after_sum_op || c.op == bcd_fix_after_difference_op) begin
          rf_we    = 1'b1;
          rf_wdata = {2{bcd_res}};
          st_next.flags.n = bcd_res[7];
          st_next.flags.z = (bcd_res == 8'h00);
          st_next.flags.c = bcd_c;
        end else begin
          rf_we    = 1'b1;
          rf_be    = c.word ? 2'b11 : rf_be;
          rf_wdata = c.word ? arith_res : {2{arith_res[7:0]}};
          st_next.flags.n = res_sign;
          st_next.flags.z = (arith_res == 16'h0000);
          st_next.flags.v = sub ? (a_sign != b_sign) && (res_sign != a_sign) :
                                  (a_sign == b_sign) && (res_sign != a_sign);
          st_next.flags.h = c.word ? half13[12] : half5[4];
          if (c.op != plus_one_op && c.op != minus_one_op) begin
            st_next.flags.c = c.word ? res17[16] : res17[8];
          end
        end
      end
      st_mem: begin
        if (mem_ack) begin
          st_next.mem.req = 1'b0;
          st_next.mem.we  = 1'b0;
          st_next.fsm     = st_idle;
          st_next.ready   = 1'b1;
          st_next.done    = 1'b1;
          if (!x_store) begin
            rf_we    = 1'b1;
            rf_be    = x_word ? 2'b11 : rf_be;
            rf_wdata = x_word ? mem_rdata : {2{mem_rdata[7:0]}};
            st_next.flags.n = x_word ? mem_rdata[15] : mem_rdata[7];
            st_next.flags.z = x_word ? (mem_rdata == 16'h0000) : (mem_rdata[7:0] == 8'h00);
            st_next.flags.v = 1'b0;
          end
        end
      end
      default: begin
        st_next.fsm = st_idle;
      end
    endcase
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      st_reg         <= '0;
      st_reg.fsm     <= st_idle;
      st_reg.ready   <= 1'b1;
      st_reg.flags   <= `FLAGS_RESET;
    end else begin
      st_reg <= st_next;
    end
  end

  assign cmd_ready = st_reg.ready;
  assign done      = st_reg.done;
  assign illegal   = st_reg.illegal;
  assign mem       = st_reg.mem;
  assign flags     = st_reg.flags;

  ////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  sequence push_issue_s;
    in_exec && c.op == stack_store_op;
  endsequence
  sequence push_write_s;
    st_reg.mem.req && st_reg.mem.we && st_reg.mem.word && st_reg.mem.addr == ($past(rf_b) - `STEP_WORD);
  endsequence
  sequence pop_issue_s;
    in_exec && c.op == stack_load_op;
  endsequence
  sequence pop_read_s;
    st_reg.mem.req && !st_reg.mem.we && st_reg.mem.word && st_reg.mem.addr == $past(rf_b);
  endsequence

  even_word_addr_a: assert property (st_reg.mem.req && st_reg.mem.word |-> !st_reg.mem.addr[0])
    else $error("word access at odd address");
  short_abs_page_a: assert property (st_reg.mem.req && c.op == transfer_op && c.mode == mode_abs8
                                     |-> st_reg.mem.addr[15:8] == `ABS8_PAGE)
    else $error("short absolute address outside top page");
  short_abs_word_a: assert property (in_exec && c.op == transfer_op && c.mode == mode_abs8 && c.word
                                     |-> !rf_we ##1 (st_reg.illegal && !st_reg.mem.req))
    else $error("word form of short absolute accepted");
  stack_store_a: assert property (push_issue_s |-> rf_we && rf_widx == `STACK_PTR_IDX ##1 push_write_s)
    else $error("stack store pointer or write wrong");
  stack_load_a: assert property (pop_issue_s |-> rf_wdata == rf_b + `STEP_WORD ##1 pop_read_s)
    else $error("stack load pointer or read wrong");
  pointer_step_a: assert property (in_exec && c.op == transfer_op && c.mode == mode_post_inc && !refuse
                                   |-> rf_we && rf_wdata == rf_b + (c.word ? `STEP_WORD : `STEP_BYTE))
    else $error("post-increment step wrong");
  periph_none_a: assert property (in_exec && (c.op == peripheral_out_transfer_op || c.op == peripheral_in_transfer_op)
                                  |-> !rf_we ##1 (st_reg.illegal && !st_reg.mem.req))
    else $error("peripheral transfer had an effect");
  sub_imm_none_a: assert property (in_exec && c.op == difference_op && c.mode == mode_immediate
                                   |-> !rf_we ##1 st_reg.illegal)
    else $error("immediate subtract accepted");
  plus_one_a: assert property (in_exec && c.op == plus_one_op && !refuse
                               |-> rf_we && pick_byte(rf_wdata, rf_be[0]) == a_byte + 8'h01)
    else $error("increment result wrong");
  zero_flag_a: assert property (in_exec && !refuse && (c.op == sum_op || c.op == difference_op)
                                |=> st_reg.flags.z == ($past(rf_wdata) == 16'h0000))
    else $error("zero flag wrong after arithmetic");
  load_done_a: assert property (st_reg.fsm == st_mem && mem_ack
                                |=> st_reg.done && !st_reg.mem.req ##1 !st_reg.done)
    else $error("transfer did not complete after acknowledge");

endmodule : transfer_arith_exec

// [mem_model.sv]
/*
  Memory partner on the internal bus: byte array, words big-endian, ack slow+1 cycles after the request rises.
  Assumes one request held until mem_ack.
*/
`timescale 1ns/1ps
module mem_model (
  // Clock and bus
  input  wire logic                    clk,
  input  wire transfer_arith_pkg::mem_out_t mem,
  input  wire logic [3:0]              slow,
  output logic      [15:0]             mem_rdata,
  output logic                         mem_ack
);
  import transfer_arith_pkg::*;
  logic [7:0] m [0:65535];
  logic [3:0] cnt = 4'h0;
  initial begin
    mem_ack = 1'b0;
    mem_rdata = 16'h5A5A;
  end
  always @(posedge clk) begin
    mem_ack <= 1'b0;
    mem_rdata <= ~mem_rdata; // Stale data inverts every cycle, so it alternates between two values
    if (mem.req && !mem_ack) begin
      cnt <= cnt + 4'h1;
      if (cnt >= slow) begin
        cnt <= 4'h0;
        mem_ack <= 1'b1;
        mem_rdata <= mem.word ? {m[mem.addr], m[mem.addr | 16'h1]} : {8'h00, m[mem.addr]};
        if (mem.we && mem.word) m[mem.addr | 16'h1] <= mem.wdata[7:0];
        if (mem.we) m[mem.addr] <= mem.word ? mem.wdata[15:8] : mem.wdata[7:0];
      end
    end
  end
endmodule : mem_model

// [tb_top.sv]
/*
  Self-checking bench for the execute block; registers are seen through stores to memory.
  Assumes mem_model and the design package.
*/
`timescale 1ns/1ps
module tb_top;
  import transfer_arith_pkg::*;
  logic clk, resetn, cmd_valid, cmd_ready, done, illegal, mem_ack;
  cmd_t cmd;
  cmd_t bad [9];
  mem_out_t mem;
  flags_t flags, fl;
  logic [15:0] mem_rdata, x, y, z;
  logic [3:0] slow;
  int failures = 0, comparisons = 0, seed = 32'h6d71;
  transfer_arith_exec dut_u (.clk(clk), .resetn(resetn), .cmd_valid(cmd_valid), .cmd(cmd), .cmd_ready(cmd_ready),
    .done(done), .illegal(illegal), .mem(mem), .mem_rdata(mem_rdata), .mem_ack(mem_ack), .flags(flags));
  mem_model mem_u (.clk(clk), .mem(mem), .slow(slow), .mem_rdata(mem_rdata), .mem_ack(mem_ack));
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  ////////////////////////////////////////////////////////////////
  function automatic cmd_t mk(op_t o, logic w, mode_t md, logic s, logic [3:0] a, logic [3:0] b, logic [15:0] e);
    return '{o, w, md, s, a, b, e};
  endfunction : mk
  function automatic logic [3:0] addf(logic [15:0] a, logic [15:0] b);
    logic [16:0] s = {1'b0, a} + {1'b0, b};
    return {s[15], s[15:0] == 16'h0, a[15] == b[15] && s[15] != a[15], s[16]};
  endfunction : addf
  function automatic logic [15:0] rd(logic [15:0] a);
    return {mem_u.m[a], mem_u.m[a + 16'h1]};
  endfunction : rd
  task automatic chk(logic [15:0] got, logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      failures++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic run(cmd_t c, logic il);
    int n = 0;
    @(posedge clk);
    cmd_valid <= 1'b1;
    cmd <= c;
    @(posedge clk);
    cmd_valid <= 1'b0;
    do begin
      @(posedge clk);
      #1 n++;
    end while (done !== 1'b1 && n < 40);
    chk({14'h0, done, illegal}, {14'h0, 1'b1, il});
  endtask : run
  task automatic li(logic [2:0] r, logic [15:0] v);
    run(mk(transfer_op, 1'b1, mode_immediate, 1'b0, {1'b0, r}, 4'h0, v), 1'b0);
  endtask : li
  task automatic st(logic [2:0] r, logic [15:0] a);
    run(mk(transfer_op, 1'b1, mode_abs16, 1'b1, {1'b0, r}, 4'h0, a), 1'b0);
  endtask : st
  task automatic print_verdict;
    $display("failures=%0d comparisons=%0d", failures, comparisons);
    if (failures == 0 && comparisons > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : print_verdict
  ////////////////////////////////////////////////////////////////
  initial begin
    #2000000 failures++;
    print_verdict();
  end
  initial begin
    resetn = 1'b0;
    cmd_valid = 1'b0;
    cmd = '0;
    slow = 4'h0;
    repeat (4) @(posedge clk);
    resetn <= 1'b1;
    @(posedge clk) #1 chk({7'h0, cmd_ready, flags}, 16'h0100);
    for (int i = 0; i < 6; i++) begin
      x = $random(seed);
      y = $random(seed);
      if (i == 0) {x, y} = {16'hFFFF, 16'h0001}; // Carry out with zero result
      if (i == 1) {x, y} = {16'h7FFF, 16'h0001}; // Signed overflow
      slow <= i[3:0];
      li(3'h0, x);
      li(3'h1, y);
      run(mk(sum_op, 1'b1, mode_register, 1'b0, 4'h0, 4'h1, 16'h0), 1'b0);
      chk({12'h0, flags[3:0]}, {12'h0, addf(x, y)});
      st(3'h0, 16'h1001);
      chk(rd(16'h1000), x + y);
    end
    z = x + y;
    li(3'h7, 16'h2000);
    run(mk(stack_store_op, 1'b1, mode_pre_decrement, 1'b1, 4'h0, 4'h7, 16'h0), 1'b0);
    chk(rd(16'h1FFE), z);
    run(mk(stack_load_op, 1'b1, mode_post_inc, 1'b0, 4'h2, 4'h7, 16'h0), 1'b0);
    st(3'h2, 16'h3000);
    chk(rd(16'h3000), z);
    st(3'h7, 16'h3002);
    chk(rd(16'h3002), 16'h2000);
    li(3'h3, 16'h1000);
    run(mk(transfer_op, 1'b0, mode_post_inc, 1'b0, 4'hC, 4'h3, 16'h0), 1'b0);
    run(mk(pointer_plus_small_op, 1'b1, mode_register, 1'b0, 4'h3, 4'h3, 16'h2), 1'b0);
    st(3'h3, 16'h3004);
    chk(rd(16'h3004), 16'h1003);
    st(3'h4, 16'h3006);
    chk(rd(16'h3006), {8'h00, z[15:8]});
    run(mk(transfer_op, 1'b0, mode_abs8, 1'b1, 4'h8, 4'h0, 16'h0034), 1'b0);
    chk({8'h0, mem_u.m[16'hFF34]}, {8'h0, z[7:0]});
    li(3'h5, 16'h0009);
    li(3'h6, 16'h0001);
    run(mk(sum_op, 1'b0, mode_register, 1'b0, 4'hD, 4'hE, 16'h0), 1'b0);
    run(mk(bcd_fix_after_sum_op, 1'b0, mode_register, 1'b0, 4'hD, 4'h0, 16'h0), 1'b0);
    run(mk(plus_one_op, 1'b0, mode_register, 1'b0, 4'hD, 4'h0, 16'h0), 1'b0);
    st(3'h5, 16'h3008);
    chk(rd(16'h3008), 16'h0011);
    li(3'h3, 16'h4000);
    run(mk(transfer_op, 1'b1, mode_disp16, 1'b1, 4'h0, 4'h3, 16'h0011), 1'b0);
    chk(rd(16'h4010), z);
    run(mk(transfer_op, 1'b1, mode_pre_decrement, 1'b1, 4'h1, 4'h3, 16'h0), 1'b0);
    run(mk(transfer_op, 1'b1, mode_indirect, 1'b0, 4'h2, 4'h3, 16'h0), 1'b0);
    run(mk(pointer_minus_small_op, 1'b1, mode_register, 1'b0, 4'h3, 4'h3, 16'h1), 1'b0);
    st(3'h2, 16'h300C);
    chk(rd(16'h300C), y);
    st(3'h3, 16'h300E);
    chk(rd(16'h300E), 16'h3FFD);
    li(3'h5, 16'h0042);
    li(3'h6, 16'h0017);
    run(mk(difference_op, 1'b0, mode_register, 1'b0, 4'hD, 4'hE, 16'h0), 1'b0);
    run(mk(bcd_fix_after_difference_op, 1'b0, mode_register, 1'b0, 4'hD, 4'h0, 16'h0), 1'b0);
    run(mk(difference_op, 1'b0, mode_register, 1'b0, 4'hE, 4'hD, 16'h0), 1'b0);
    chk({12'h0, flags[3:0]}, 16'h0009);
    run(mk(difference_with_borrow_op, 1'b0, mode_immediate, 1'b0, 4'hD, 4'h0, 16'h0020), 1'b0);
    run(mk(sum_with_carry_op, 1'b0, mode_register, 1'b0, 4'hD, 4'hE, 16'h0), 1'b0);
    run(mk(minus_one_op, 1'b0, mode_register, 1'b0, 4'hD, 4'h0, 16'h0), 1'b0);
    st(3'h5, 16'h3010);
    chk(rd(16'h3010), 16'h00F5);
    st(3'h6, 16'h3012);
    chk(rd(16'h3012), 16'h00F2);
    bad[0] = mk(transfer_op, 1'b1, mode_abs8, 1'b1, 4'h0, 4'h0, 16'h0040);
    bad[1] = mk(difference_op, 1'b0, mode_immediate, 1'b0, 4'h8, 4'h0, 16'h5);
    bad[2] = mk(sum_op, 1'b1, mode_immediate, 1'b0, 4'h0, 4'h0, 16'h5);
    bad[3] = mk(sum_with_carry_op, 1'b1, mode_register, 1'b0, 4'h0, 4'h1, 16'h0);
    bad[4] = mk(minus_one_op, 1'b1, mode_register, 1'b0, 4'h0, 4'h0, 16'h0);
    bad[5] = mk(pointer_minus_small_op, 1'b1, mode_register, 1'b0, 4'h3, 4'h3, 16'h3);
    bad[6] = mk(bcd_fix_after_difference_op, 1'b1, mode_register, 1'b0, 4'h0, 4'h0, 16'h0);
    bad[7] = mk(peripheral_out_transfer_op, 1'b0, mode_abs16, 1'b1, 4'h8, 4'h0, 16'h0040);
    bad[8] = mk(peripheral_in_transfer_op, 1'b0, mode_abs16, 1'b0, 4'h8, 4'h0, 16'h0040);
    fl = flags;
    foreach (bad[j]) begin
      run(bad[j], 1'b1);
      chk({8'h0, flags}, {8'h0, fl});
    end
    st(3'h0, 16'h300A);
    chk(rd(16'h300A), z);
    print_verdict();
  end
endmodule : tb_top
